// *** logic/ddrc_pkg.sv ***
// Purpose: Shared constants and types for the DDR command and mode logic
// Assumes: Controller logic runs on the same clock as this block
// Notes: Mode field positions follow the opcode carried on the address bits
package ddrc_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned BANK_N = 4;
  localparam int unsigned DATA_W = 8;

  // ==========================================================================
  // Base mode register opcode fields
  localparam int unsigned MR_BL_LSB = 0;
  localparam int unsigned MR_BT_BIT = 3;
  localparam int unsigned MR_LAT_LSB = 4;
  localparam int unsigned MR_OPMODE_LSB = 7;
  localparam logic [5:0] MR_OPMODE_NORMAL = 6'h00;
  localparam logic [5:0] MR_OPMODE_DLL_RST = 6'h02;

  // Burst length codes
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;

  // Read latency codes
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [2:0] LAT_2P5 = 3'h6;

  // ==========================================================================
  // Extended mode register fields
  localparam int unsigned EMR_DLL_DIS_BIT = 0;
  localparam int unsigned EMR_DRIVE_BIT = 1;

  // Bank select codes for load mode register
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h1;

  // ==========================================================================
  // Reset values and timing
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0032;
  localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000;
  localparam int unsigned DLL_LOCK_CYC = 200;
  localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CYC - 1);

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    DDRC_NOP, DDRC_ACT, DDRC_RD, DDRC_WR, DDRC_BST,
    DDRC_PRE, DDRC_AREF, DDRC_SREF, DDRC_LMR
  } ddrc_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic bank_select_high;
    logic bank_select_low;
    logic [ADDR_W-1:0] addr;
  } ddrc_pins_t;

  typedef struct packed {
    logic [2:0] latency;
    logic interleave;
    logic [2:0] burst_len;
  } ddrc_mode_t;

  // Command decode from the four strobes and clock enable
  function automatic ddrc_cmd_t ddrc_decode(input ddrc_pins_t p);
    ddrc_cmd_t c;
    c = DDRC_NOP;
    if (!p.cs_n) begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        3'b111: c = DDRC_NOP;
        3'b011: c = DDRC_ACT;
        3'b101: c = DDRC_RD;
        3'b100: c = DDRC_WR;
        3'b110: c = DDRC_BST;
        3'b010: c = DDRC_PRE;
        3'b001: c = p.cke ? DDRC_AREF : DDRC_SREF;
        3'b000: c = DDRC_LMR;
      endcase
    end
    return c;
  endfunction

  // Low address bits that stay inside a burst block
  function automatic logic [2:0] ddrc_blk_mask(input logic [2:0] bl);
    logic [2:0] m;
    m = 3'h0;
    unique case (bl)
      BL_2: m = 3'h1;
      BL_4: m = 3'h3;
      BL_8: m = 3'h7;
      default: m = 3'h0;
    endcase
    return m;
  endfunction

endpackage

// *** logic/ddrc_burst.sv ***
// Purpose: Column address sequencer for one burst with block wrap
// Assumes: One element per clock; start reloads at any time
// Notes: Stop ends a running burst at once
`timescale 1ns/1ps
`default_nettype none
module ddrc_burst
  import ddrc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic [ADDR_W-1:0] start_col,
  input wire logic [2:0] burst_len,
  input wire logic interleave,
  output logic busy_q,
  output logic last_q,
  output logic [ADDR_W-1:0] col_q
);

  // ==========================================================================
  // Sequencer state
  logic [2:0] idx_q, idx_d;
  logic [2:0] mask_q, mask_d;
  logic [ADDR_W-1:0] base_q, base_d;
  logic ilv_q, ilv_d;
  logic busy_d, last_d;
  logic [ADDR_W-1:0] col_d;
  logic [2:0] off;

  always_comb begin
    idx_d = idx_q;
    mask_d = mask_q;
    base_d = base_q;
    ilv_d = ilv_q;
    busy_d = busy_q;
    if (start) begin
      idx_d = 3'h0;
      mask_d = ddrc_blk_mask(burst_len);
      base_d = start_col;
      ilv_d = interleave;
      busy_d = 1'b1;
    end else if (stop || last_q) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      idx_d = idx_q + 3'h1;
    end
    // Wrap within the aligned block
    if (ilv_d) begin
      off = base_d[2:0] ^ idx_d;
    end else begin
      off = base_d[2:0] + idx_d;
    end
    col_d = {base_d[ADDR_W-1:3], (base_d[2:0] & ~mask_d) | (off & mask_d)};
    last_d = busy_d && (idx_d == mask_d);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= 3'h0;
      mask_q <= 3'h0;
      base_q <= '0;
      ilv_q <= 1'b0;
      busy_q <= 1'b0;
      last_q <= 1'b0;
      col_q <= '0;
    end else begin
      idx_q <= idx_d;
      mask_q <= mask_d;
      base_q <= base_d;
      ilv_q <= ilv_d;
      busy_q <= busy_d;
      last_q <= last_d;
      col_q <= col_d;
    end
  end

endmodule
`default_nettype wire

// *** logic/ddrc_core.sv ***
// Function
// - Read latency programmable: 2, 2.5, 3
// - First read data at edge n+m
// - Zero A7-A12 loads normal mode settings
// - A8 alone set starts DLL reset
// - Bank 01 load writes retained extended register
// - Extended register holds DLL and drive
// - Self refresh exit re-enables DLL itself
// - Deselect and NOP do nothing
// - Activate opens row in selected bank
// - Read or write; A10 auto precharge
// - Burst terminate only for plain reads
// - Precharge one bank, or all on A10
// - Auto refresh, or self refresh entry
// - Load mode register; reserved bank codes
// - Write mask blocks element when high
// - Burst wraps within its aligned block
//
// Purpose: Command decode, mode registers, read timing and write masking
// Assumes: Controller drives pins from logic on this same clock
// Notes: One data element per clock; refresh rows come from an internal counter
`timescale 1ns/1ps
`default_nettype none
module ddrc_core
  import ddrc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire ddrc_pins_t pins,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic write_mask,
  output ddrc_mode_t mode_q,
  output logic dll_enabled_q,
  output logic drive_strength_q,
  output logic dll_reset_q,
  output logic dll_ready_q,
  output logic self_refresh_q,
  output logic refresh_q,
  output logic [ADDR_W-1:0] refresh_row_q,
  output logic [BANK_N-1:0] bank_open_q,
  output logic [ADDR_W-1:0] act_row_q,
  output logic rd_first_q,
  output logic rd_half_q,
  output logic burst_busy_q,
  output logic burst_write_q,
  output logic [ADDR_W-1:0] burst_col_q,
  output logic wr_commit_q,
  output logic [DATA_W-1:0] wr_data_q,
  output logic illegal_q
);

  // ==========================================================================
  // Decode
  ddrc_cmd_t cmd;
  logic [1:0] bsel;
  logic [5:0] opmode;
  logic mr_fields_ok;

  always_comb begin
    cmd = ddrc_decode(pins);
    bsel = {pins.bank_select_high, pins.bank_select_low};
    opmode = pins.addr[ADDR_W-1:MR_OPMODE_LSB];
    mr_fields_ok = (ddrc_blk_mask(pins.addr[MR_BL_LSB +: 3]) != 3'h0)
      && (pins.addr[MR_LAT_LSB +: 3] == LAT_2 || pins.addr[MR_LAT_LSB +: 3] == LAT_3
      || pins.addr[MR_LAT_LSB +: 3] == LAT_2P5);
  end

  // ==========================================================================
  // Mode, DLL and refresh state
  ddrc_mode_t mode_d;
  logic dll_enabled_d, drive_strength_d, dll_reset_d, dll_ready_d;
  logic self_refresh_d, refresh_d;
  logic [ADDR_W-1:0] refresh_row_d;
  logic [7:0] lock_cnt_q, lock_cnt_d;
  logic lock_run_q, lock_run_d;
  logic mode_ill;

  always_comb begin
    mode_d = mode_q;
    dll_enabled_d = dll_enabled_q;
    drive_strength_d = drive_strength_q;
    dll_reset_d = 1'b0;
    dll_ready_d = dll_ready_q;
    self_refresh_d = self_refresh_q;
    refresh_d = 1'b0;
    refresh_row_d = refresh_row_q;
    lock_cnt_d = lock_cnt_q;
    lock_run_d = lock_run_q;
    mode_ill = 1'b0;
    if (self_refresh_q) begin
      if (pins.cke) begin
        self_refresh_d = 1'b0;
        dll_enabled_d = 1'b1;
      end
    end else if (cmd == DDRC_LMR) begin
      if (bsel == SEL_BASE) begin
        if (mr_fields_ok && (opmode == MR_OPMODE_NORMAL || opmode == MR_OPMODE_DLL_RST)) begin
          mode_d.burst_len = pins.addr[MR_BL_LSB +: 3];
          mode_d.interleave = pins.addr[MR_BT_BIT];
          mode_d.latency = pins.addr[MR_LAT_LSB +: 3];
          if (opmode == MR_OPMODE_DLL_RST) begin
            dll_reset_d = 1'b1;
            dll_ready_d = 1'b0;
            lock_run_d = 1'b1;
            lock_cnt_d = 8'h00;
          end
        end else begin
          mode_ill = 1'b1;
        end
      end else if (bsel == SEL_EXT) begin
        dll_enabled_d = ~pins.addr[EMR_DLL_DIS_BIT];
        drive_strength_d = pins.addr[EMR_DRIVE_BIT];
        if (pins.addr[EMR_DLL_DIS_BIT]) begin
          dll_ready_d = 1'b0;
          lock_run_d = 1'b0;
        end
      end else begin
        mode_ill = 1'b1;
      end
    end else if (cmd == DDRC_AREF || cmd == DDRC_SREF) begin
      refresh_d = (cmd == DDRC_AREF);
      self_refresh_d = (cmd == DDRC_SREF);
      refresh_row_d = refresh_row_q + 13'h0001;
    end
    // Lock wait counts only while clock enable is high
    if (lock_run_q && !dll_reset_d && pins.cke && dll_enabled_q) begin
      if (lock_cnt_q == DLL_LOCK_CNT) begin
        lock_run_d = 1'b0;
        dll_ready_d = 1'b1;
      end else begin
        lock_cnt_d = lock_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= ddrc_mode_t'(MR_RESET[6:0]);
      dll_enabled_q <= ~EMR_RESET[EMR_DLL_DIS_BIT];
      drive_strength_q <= EMR_RESET[EMR_DRIVE_BIT];
      dll_reset_q <= 1'b0;
      dll_ready_q <= 1'b0;
      self_refresh_q <= 1'b0;
      refresh_q <= 1'b0;
      refresh_row_q <= '0;
      lock_cnt_q <= 8'h00;
      lock_run_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      dll_enabled_q <= dll_enabled_d;
      drive_strength_q <= drive_strength_d;
      dll_reset_q <= dll_reset_d;
      dll_ready_q <= dll_ready_d;
      self_refresh_q <= self_refresh_d;
      refresh_q <= refresh_d;
      refresh_row_q <= refresh_row_d;
      lock_cnt_q <= lock_cnt_d;
      lock_run_q <= lock_run_d;
    end
  end

  // ==========================================================================
  // Banks, bursts, read timing and write data
  logic [BANK_N-1:0] bank_open_d;
  logic [ADDR_W-1:0] act_row_d;
  logic [2:0] rd_pipe_q, rd_pipe_d;
  logic rd_first_d, rd_half_d;
  logic burst_write_d, ap_q, ap_d;
  logic [1:0] ap_bank_q, ap_bank_d;
  logic wr_commit_d;
  logic [DATA_W-1:0] wr_data_d;
  logic illegal_d;
  logic b_start, b_stop, b_last;
  logic [1:0] bank;
  logic live;

  always_comb begin
    live = !self_refresh_q;
    bank = bsel;
    bank_open_d = bank_open_q;
    act_row_d = act_row_q;
    burst_write_d = burst_write_q;
    ap_d = ap_q;
    ap_bank_d = ap_bank_q;
    b_start = 1'b0;
    b_stop = 1'b0;
    illegal_d = mode_ill;
    if (b_last && ap_q && burst_busy_q) begin
      bank_open_d[ap_bank_q] = 1'b0;
    end
    if (live) begin
      unique case (cmd)
        DDRC_ACT: begin
          bank_open_d[bank] = 1'b1;
          act_row_d = pins.addr;
        end
        DDRC_RD, DDRC_WR: begin
          b_start = 1'b1;
          burst_write_d = (cmd == DDRC_WR);
          ap_d = pins.addr[10];
          ap_bank_d = bank;
        end
        DDRC_BST: begin
          if (burst_busy_q && (burst_write_q || ap_q)) begin
            illegal_d = 1'b1;
          end else begin
            b_stop = 1'b1;
          end
        end
        DDRC_PRE: begin
          if (pins.addr[10]) begin
            bank_open_d = '0;
          end else begin
            bank_open_d[bank] = 1'b0;
          end
        end
        DDRC_SREF: begin
          bank_open_d = '0;
        end
        default: begin
        end
      endcase
    end
    // Read data timing from the command edge
    rd_pipe_d = {rd_pipe_q[1:0], live && cmd == DDRC_RD};
    if (mode_q.latency == LAT_3) begin
      rd_first_d = rd_pipe_q[2];
    end else begin
      rd_first_d = rd_pipe_q[1];
    end
    rd_half_d = rd_first_d && (mode_q.latency == LAT_2P5);
    // Masked elements never reach the array
    wr_commit_d = burst_busy_q && burst_write_q && !write_mask;
    wr_data_d = wr_commit_d ? wr_data : wr_data_q;
  end

  ddrc_burst u_burst (
    .clock(clock),
    .arst_n(arst_n),
    .start(b_start),
    .stop(b_stop),
    .start_col(pins.addr),
    .burst_len(mode_q.burst_len),
    .interleave(mode_q.interleave),
    .busy_q(burst_busy_q),
    .last_q(b_last),
    .col_q(burst_col_q)
  );

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_open_q <= '0;
      act_row_q <= '0;
      rd_pipe_q <= 3'h0;
      rd_first_q <= 1'b0;
      rd_half_q <= 1'b0;
      burst_write_q <= 1'b0;
      ap_q <= 1'b0;
      ap_bank_q <= 2'h0;
      wr_commit_q <= 1'b0;
      wr_data_q <= '0;
      illegal_q <= 1'b0;
    end else begin
      bank_open_q <= bank_open_d;
      act_row_q <= act_row_d;
      rd_pipe_q <= rd_pipe_d;
      rd_first_q <= rd_first_d;
      rd_half_q <= rd_half_d;
      burst_write_q <= burst_write_d;
      ap_q <= ap_d;
      ap_bank_q <= ap_bank_d;
      wr_commit_q <= wr_commit_d;
      wr_data_q <= wr_data_d;
      illegal_q <= illegal_d;
    end
  end

endmodule
`default_nettype wire

// *** verification/ddrc_core_monitor.sv ***
// Purpose: Port-level assertions for the command and mode logic
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to ddrc_core after the module
`timescale 1ns/1ps
`default_nettype none
module ddrc_core_monitor
  import ddrc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire ddrc_pins_t pins,
  input wire logic write_mask,
  input wire ddrc_mode_t mode_q,
  input wire logic dll_enabled_q,
  input wire logic drive_strength_q,
  input wire logic dll_reset_q,
  input wire logic self_refresh_q,
  input wire logic refresh_q,
  input wire logic [ADDR_W-1:0] refresh_row_q,
  input wire logic [BANK_N-1:0] bank_open_q,
  input wire logic [ADDR_W-1:0] act_row_q,
  input wire logic rd_first_q,
  input wire logic burst_busy_q,
  input wire logic burst_write_q,
  input wire logic [ADDR_W-1:0] burst_col_q,
  input wire logic wr_commit_q,
  input wire logic illegal_q
);
  // ==========
  // Decode helpers
  wire logic [3:0] s = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  wire logic [1:0] ba = {pins.bank_select_high, pins.bank_select_low};
  wire logic go = !self_refresh_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ==========
  // Assertions
  property p_nop;
    pins.cs_n |=> !refresh_q && !dll_reset_q && !illegal_q;
  endproperty
  a_nop: assert property (p_nop) else $error("deselect had an effect");
  property p_act;
    s == 4'h3 && go |=> bank_open_q[$past(ba)] && act_row_q == $past(pins.addr);
  endproperty
  a_act: assert property (p_act) else $error("activate not applied");
  property p_pre;
    s == 4'h2 && pins.addr[10] && go |=> bank_open_q == 4'h0;
  endproperty
  a_pre: assert property (p_pre) else $error("precharge all left a bank open");
  property p_ref;
    s == 4'h1 && pins.cke && go |=> refresh_q && refresh_row_q == $past(refresh_row_q) + 13'h1;
  endproperty
  a_ref: assert property (p_ref) else $error("auto refresh missing");
  property p_emr;
    s == 4'h0 && ba == SEL_EXT && go |=> dll_enabled_q == !$past(pins.addr[0]) && drive_strength_q == $past(pins.addr[1]);
  endproperty
  a_emr: assert property (p_emr) else $error("extended load wrong");
  property p_rsv;
    s == 4'h0 && ba[1] && go |=> illegal_q && $stable(mode_q);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved select accepted");
  property p_lat3;
    s == 4'h5 && go && mode_q.latency == LAT_3 |=> ##3 rd_first_q;
  endproperty
  a_lat3: assert property (p_lat3) else $error("read data late or early");
  property p_lat2;
    s == 4'h5 && go && mode_q.latency != LAT_3 |=> ##2 rd_first_q;
  endproperty
  a_lat2: assert property (p_lat2) else $error("short latency read data misplaced");
  property p_rw;
    s[3:1] == 3'b010 && go |=> burst_busy_q && burst_write_q == !$past(pins.we_n)
      && burst_col_q == $past(pins.addr);
  endproperty
  a_rw: assert property (p_rw) else $error("burst did not start");
  property p_mask;
    burst_busy_q && burst_write_q && write_mask |=> !wr_commit_q;
  endproperty
  a_mask: assert property (p_mask) else $error("masked element written");
  property p_wrap;
    burst_busy_q && mode_q.burst_len == BL_4 && !mode_q.interleave && s[3:1] != 3'b010 ##1 burst_busy_q
      |-> burst_col_q[1:0] == $past(burst_col_q[1:0]) + 2'h1 && burst_col_q[12:2] == $past(burst_col_q[12:2]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst left its block");
endmodule
bind ddrc_core ddrc_core_monitor mon_u (.*);
`default_nettype wire

// *** verification/ddrc_ctrl_model.sv ***
// Purpose: Memory controller model driving command pins and write data
// Assumes: Same clock as the block
// Notes: The bench calls its tasks
`timescale 1ns/1ps
`default_nettype none
module ddrc_ctrl_model
  import ddrc_pkg::*;
#(
  parameter int FREQ_MHZ = 100
)
(
  input wire logic clock,
  output var ddrc_pins_t pins,
  output var logic [DATA_W-1:0] wr_data,
  output var logic write_mask
);
  int lock_cnt = 0;
  logic [2:0] lat = (FREQ_MHZ > 133) ? LAT_3 : LAT_2P5;
  initial begin
    pins = {4'hf, 1'b1, 2'h0, 13'h0};
    wr_data = 8'h00;
    write_mask = 1'b1;
  end

  // ==========
  // Clock-enable-high cycles since the last DLL reset
  always @(posedge clock) begin
    if ({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n, pins.bank_select_high, pins.bank_select_low} == 6'h0 && pins.addr[8])
      lock_cnt <= 0;
    else
      lock_cnt <= lock_cnt + int'(pins.cke);
  end

  // ==========
  // Command tasks; lines are scrambled once released
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k = 1'b1);
    @(posedge clock);
    pins <= {c, k, b, a};
    @(posedge clock);
    pins <= {4'hf, k, ~b, ~a};
  endtask

  task automatic init(input logic [12:0] emr);
    cmd(4'h0, SEL_EXT, emr);
    cmd(4'h0, SEL_BASE, {MR_OPMODE_DLL_RST, lat, 1'b0, BL_4});
    cmd(4'h0, SEL_BASE, {MR_OPMODE_NORMAL, lat, 1'b0, BL_4});
  endtask

  task automatic rd(input logic [12:0] col);
    while (lock_cnt < DLL_LOCK_CYC) @(posedge clock);
    cmd(4'h5, SEL_BASE, col);
  endtask

  task automatic wr(input logic [12:0] col, input logic [31:0] d, input logic [3:0] m);
    cmd(4'h4, SEL_BASE, col);
    for (int i = 0; i < 4; i++) begin
      wr_data <= d[8*i+:8];
      write_mask <= m[i];
      @(posedge clock);
    end
    wr_data <= ~wr_data;
    write_mask <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verification/ddr_sdram_command_and_mode_logic_tb.sv ***
// Purpose: Self-checking bench for the command and mode logic
// Assumes: Controller model drives every block input but clock and reset
// Notes: Pulsed results are matched in order against a queue of expected events
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %0t: %h vs %h", $time, a, e); end end
module ddr_sdram_command_and_mode_logic_tb
  import ddrc_pkg::*;
;
  typedef logic [13:0] ddrc_ev_t;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  ddrc_pins_t pins;
  logic [DATA_W-1:0] wr_data, wr_data_q;
  logic write_mask;
  ddrc_mode_t mode_q;
  logic dll_enabled_q, drive_strength_q, dll_reset_q, dll_ready_q, self_refresh_q, refresh_q;
  logic rd_first_q, rd_half_q, burst_busy_q, burst_write_q, wr_commit_q, illegal_q;
  logic [ADDR_W-1:0] refresh_row_q, act_row_q, burst_col_q;
  logic [BANK_N-1:0] bank_open_q;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  ddrc_ev_t exp_q[$];
  ddrc_ev_t e;
  logic [31:0] d;
  logic [3:0] m;
  logic [12:0] r;
  logic [14:0] bad[3] = '{15'h0082, 15'h0012, 15'h4000};
  logic [2:0] lats[3] = '{LAT_2, LAT_2P5, LAT_3};
  logic [2:0] ilv8[8] = '{3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};
  wire ddrc_ev_t ev = {illegal_q, refresh_q, dll_reset_q, rd_first_q, rd_half_q, wr_commit_q,
                       wr_commit_q ? wr_data_q : 8'h00};

  ddrc_core dut_u (.*);
  ddrc_ctrl_model ctl_u (.clock, .pins, .wr_data, .write_mask);

  initial forever #5 clock = ~clock;

  task automatic complete_run();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========
  // Scoreboard and timeout
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end else if (arst_n && |ev[13:8]) begin
      e = exp_q.size() ? exp_q.pop_front() : 14'h0;
      `CHK(ev, e)
    end
  end

  // ==========
  // Scenarios
  initial begin
    void'($urandom(32'h8ef4));
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    `CHK({mode_q, dll_enabled_q}, {MR_RESET[6:0], !EMR_RESET[EMR_DLL_DIS_BIT]})
    exp_q.push_back(14'h0800);
    ctl_u.init(13'h0002);
    @(negedge clock);
    `CHK({mode_q, dll_enabled_q, drive_strength_q}, {ctl_u.lat, 1'b0, BL_4, 2'b11})
    foreach (bad[i]) begin
      exp_q.push_back(14'h2000);
      ctl_u.cmd(4'h0, bad[i][14:13], bad[i][12:0]);
      @(negedge clock);
      `CHK(mode_q, {ctl_u.lat, 1'b0, BL_4})
    end
    ctl_u.cmd(4'h0, SEL_BASE, {MR_OPMODE_NORMAL, ctl_u.lat, 1'b1, BL_8});
    exp_q.push_back(ctl_u.lat == LAT_2P5 ? 14'h0600 : 14'h0400);
    ctl_u.rd(13'h0005);
    foreach (ilv8[i]) begin
      @(negedge clock);
      `CHK({burst_busy_q, burst_write_q, burst_col_q}, {2'b10, 10'h000, ilv8[i]})
    end
    @(negedge clock);
    `CHK(burst_busy_q, 1'b0)
    foreach (lats[i]) begin
      ctl_u.cmd(4'h0, SEL_BASE, {MR_OPMODE_NORMAL, lats[i], 1'b0, BL_4});
      @(negedge clock);
      `CHK(mode_q, {lats[i], 1'b0, BL_4})
      exp_q.push_back(lats[i] == LAT_2P5 ? 14'h0600 : 14'h0400);
      ctl_u.rd(13'($urandom) & 13'h1bff);
      @(negedge clock);
      `CHK(dll_ready_q, 1'b1)
      repeat (6) @(posedge clock);
    end
    d = $urandom;
    m = 4'($urandom);
    for (int i = 0; i < 4; i++) if (!m[i]) exp_q.push_back({6'h01, d[8*i+:8]});
    ctl_u.wr(13'h0006, d, m);
    exp_q.push_back({6'h01, d[7:0]});
    exp_q.push_back(14'h2000);
    fork
      ctl_u.wr(13'h0000, d, 4'he);
      begin
        repeat (2) @(posedge clock);
        ctl_u.cmd(4'h6, 2'h0, 13'h0);
      end
    join
    for (int b = 0; b < 4; b++) begin
      r = 13'($urandom);
      ctl_u.cmd(4'h3, 2'(b), r);
      @(negedge clock);
      `CHK({bank_open_q[b], act_row_q}, {1'b1, r})
    end
    exp_q.push_back(14'h0400);
    ctl_u.rd(13'h0400);
    repeat (6) @(posedge clock);
    @(negedge clock);
    `CHK(bank_open_q, 4'he)
    ctl_u.cmd(4'h2, 2'h1, 13'h0000);
    @(negedge clock);
    `CHK(bank_open_q, 4'hc)
    ctl_u.cmd(4'h2, 2'h1, 13'h0400);
    @(negedge clock);
    `CHK(bank_open_q, 4'h0)
    exp_q.push_back(14'h1000);
    ctl_u.cmd(4'h1, 2'h0, 13'h0);
    ctl_u.cmd(4'h0, SEL_EXT, 13'h0001);
    @(negedge clock);
    `CHK({refresh_row_q, dll_enabled_q}, {13'h0001, 1'b0})
    ctl_u.cmd(4'h1, 2'h0, 13'h0, 1'b0);
    ctl_u.cmd(4'h0, SEL_EXT, 13'h0002, 1'b0);
    @(negedge clock);
    `CHK({self_refresh_q, refresh_row_q, drive_strength_q}, {1'b1, 13'h0002, 1'b0})
    ctl_u.cmd(4'hf, 2'h0, 13'h0);
    @(negedge clock);
    `CHK({self_refresh_q, dll_enabled_q, drive_strength_q}, 3'b010)
    repeat (4) @(posedge clock);
    `CHK(exp_q.size(), 0)
    complete_run();
  end
endmodule
`default_nettype wire
